// *** hdl/mode_params_pkg.sv ***
// constants and types shared by the mode parameter block
`default_nettype none
package mode_params_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFS_HEADER = 8'h00;
  localparam logic [7:0] OFS_PAGE_QUERY = 8'h04;
  localparam logic [7:0] OFS_CACHE_W0 = 8'h08;
  localparam logic [7:0] OFS_CACHE_W1 = 8'h0c;
  localparam logic [7:0] OFS_CACHE_W2 = 8'h10;
  localparam logic [7:0] OFS_NOTCH = 8'h14;
  localparam logic [7:0] OFS_SAVE = 8'h18;
  localparam logic [7:0] OFS_XFER_LEN = 8'h1c;
  // device specific parameter byte layout
  localparam int DSP_LOCKED_BIT = 7;
  localparam int DSP_HINT_BIT = 4;
  // page query register layout
  localparam int PQ_SENSE_BIT = 8;
  localparam int PQ_ACCEPT_BIT = 16;
  // caching page layout
  localparam logic [5:0] PAGE_CACHING = 6'h08;
  localparam logic [7:0] CACHING_PAGE_LEN = 8'h0a;
  localparam int SAVEABLE_BIT = 7;
  localparam int WBE_BIT = 2;
  localparam int SCALE_BIT = 1;
  localparam int BYPASS_BIT = 0;
  // other page codes
  localparam logic [5:0] PAGE_RW_RECOVERY = 6'h01;
  localparam logic [5:0] PAGE_DISCONNECT = 6'h02;
  localparam logic [5:0] PAGE_FORMAT = 6'h03;
  localparam logic [5:0] PAGE_GEOMETRY = 6'h04;
  localparam logic [5:0] PAGE_FLEXIBLE = 6'h05;
  localparam logic [5:0] PAGE_RESERVED_LONE = 6'h06;
  localparam logic [5:0] PAGE_VERIFY_RECOVERY = 6'h07;
  localparam logic [5:0] PAGE_PERIPHERAL = 6'h09;
  localparam logic [5:0] PAGE_CONTROL = 6'h0a;
  localparam logic [5:0] PAGE_NOTCH = 6'h0c;
  localparam logic [5:0] PAGE_RESV_LO = 6'h0d;
  localparam logic [5:0] PAGE_RESV_HI = 6'h1f;
  localparam logic [5:0] PAGE_VENDOR_PLAIN = 6'h00;
  localparam logic [5:0] PAGE_VENDOR_LO = 6'h20;
  localparam logic [5:0] PAGE_VENDOR_HI = 6'h3e;
  // code of the return-all-pages request
  localparam logic [5:0] PAGE_ALL = 6'h3f;
  // retention priority nibble codes
  localparam logic [3:0] RET_EQUAL = 4'h0;
  localparam logic [3:0] RET_SOONER = 4'h1;
  localparam logic [3:0] RET_KEEP = 4'hf;
  // reset values of the caching fields
  localparam logic [2:0] CACHE_BITS_RST = 3'h0;
  localparam logic [15:0] PREFETCH_FIELD_RST = 16'h0000;

  typedef enum logic [1:0] {
    PG_KNOWN = 2'h0,
    PG_RESERVED = 2'h1,
    PG_VENDOR = 2'h3,
    PG_ALL = 2'h2
  } page_class_t;

  typedef enum logic [1:0] {
    KEEP_EQUAL = 2'h0,
    KEEP_SHORT = 2'h1,
    KEEP_LONG = 2'h3
  } retain_t;

  // classify a six-bit mode page code
  function automatic page_class_t classifyPage(input logic [5:0] code);
    page_class_t cls;
    cls = PG_RESERVED;
    if (code == PAGE_ALL) begin
      cls = PG_ALL;
    end else if (code == PAGE_VENDOR_PLAIN || (code >= PAGE_VENDOR_LO && code <= PAGE_VENDOR_HI)) begin
      cls = PG_VENDOR;
    end else if (code == PAGE_RESERVED_LONE || (code >= PAGE_RESV_LO && code <= PAGE_RESV_HI)) begin
      cls = PG_RESERVED;
    end else if (code == PAGE_CACHING || code == PAGE_CONTROL || code == PAGE_DISCONNECT ||
                 code == PAGE_FLEXIBLE || code == PAGE_FORMAT || code == PAGE_NOTCH ||
                 code == PAGE_PERIPHERAL || code == PAGE_RW_RECOVERY || code == PAGE_GEOMETRY ||
                 code == PAGE_VERIFY_RECOVERY) begin
      cls = PG_KNOWN;
    end
    return cls;
  endfunction

  // decode a retention nibble; reserved codes fall back to no distinction
  function automatic retain_t decodeRetain(input logic [3:0] nib);
    retain_t r;
    r = KEEP_EQUAL;
    if (nib == RET_SOONER) begin
      r = KEEP_SHORT;
    end else if (nib == RET_KEEP) begin
      r = KEEP_LONG;
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// *** hdl/prefetch_calc.sv ***
// prefetch block counts from the caching page fields
`default_nettype none
module prefetch_calc #(
  parameter int FIELD_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // caching page fields and transfer length
  input wire logic scaleSelect,
  input wire logic [FIELD_W-1:0] minField,
  input wire logic [FIELD_W-1:0] maxField,
  input wire logic [FIELD_W-1:0] ceilField,
  input wire logic [FIELD_W-1:0] xferLen,
  // resulting counts
  output logic [2*FIELD_W-1:0] minBlocks,
  output logic [2*FIELD_W-1:0] maxBlocks
);
  import mode_params_pkg::*;

  logic [2*FIELD_W-1:0] minScaled;
  logic [2*FIELD_W-1:0] maxScaled;
  logic [2*FIELD_W-1:0] ceilWide;

  // widen first so the product keeps every bit of both fields
  function automatic logic [2*FIELD_W-1:0] scaleField(
    input logic [FIELD_W-1:0] fld,
    input logic [FIELD_W-1:0] len,
    input logic sel
  );
    logic [2*FIELD_W-1:0] wideFld;
    logic [2*FIELD_W-1:0] wideLen;
    wideFld = {{FIELD_W{1'b0}}, fld};
    wideLen = {{FIELD_W{1'b0}}, len};
    return sel ? wideFld * wideLen : wideFld;
  endfunction

  // plain counts or scaled by the transfer length
  always_comb begin
    minScaled = scaleField(minField, xferLen, scaleSelect); // see (RL17) (RL18)
    maxScaled = scaleField(maxField, xferLen, scaleSelect); // see (RL17) (RL18)
    ceilWide = {{FIELD_W{1'b0}}, ceilField};
  end

  // registered so the counts stay steady between commands; ceiling trims the maximum
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      minBlocks <= '0;
      maxBlocks <= '0;
    end else begin
      minBlocks <= minScaled;
      maxBlocks <= (maxScaled > ceilWide) ? ceilWide : maxScaled;
    end
  end
endmodule
`default_nettype wire

// *** hdl/mode_params_target.sv ***
// mode parameter target: header byte, page codes, notch scope and caching page
//
// How it works
// (RL1) device specific byte: locked flag bit 7, cache hint support bit 4, rest reserved.
// (RL2) locked flag position in a select header is ignored.
// (RL3) sense reports locked flag one when medium write protected, else zero.
// (RL4) cache hint position in a select header is ignored.
// (RL5) sense reports cache hint one exactly when the target honours those bits.
// (RL6) density code in the block descriptor is reserved: reads zero, writes ignored.
// (RL7) page codes decoded into known, reserved, vendor and all-pages classes.
// (RL8) all-pages request accepted for sense only, refused for select.
// (RL9) without notch page or with active notch zero, pages apply to whole unit.
// (RL10) with notch page and active notch nonzero, pages apply to that notch only.
// (RL11) caching page byte 0: saveable flag bit 7, code 08h; byte 1 length.
// (RL12) caching page bytes 2 to 11 hold control bits, priorities, four prefetch words.
// (RL13) saveable flag only reported in sense; ignored on select.
// (RL14) reported saveable means a select with save flag stores the page.
// (RL15) write-back off: good status only after medium write completes.
// (RL16) write-back on: good status allowed once all data received.
// (RL17) scale off: prefetch fields are plain block counts.
// (RL18) scale on: prefetch fields multiplied by current transfer length.
// (RL19) bypass off: read data may come from cache or medium.
// (RL20) bypass on: every read byte comes from the medium.
// (RL21) demand-read nibble advises retention of delivered read data.
// (RL22) nibble 0h equal, 1h sooner, Fh keep; 2h to Eh reserved.
// (RL23) write nibble advises retention of committed write data.
// (RL24) reserved bits read zero and are ignored when written.
`default_nettype none
module mode_params_target #(
  parameter bit HINT_SUPPORTED = 1'b1,
  parameter bit NOTCH_SUPPORTED = 1'b1,
  parameter bit PAGE_SAVEABLE = 1'b1,
  parameter int FIELD_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // medium write protect pin
  input wire logic writeProtectPin,
  // command engine events on this clock
  input wire logic writeDataDone,
  input wire logic writeMediumDone,
  input wire logic readCacheHit,
  // command engine controls
  output logic writeGoodStatus,
  output logic readFromCache,
  output logic savePageReq,
  output logic scopeIsNotch,
  output logic [7:0] scopeNotch,
  output logic [1:0] readRetain,
  output logic [1:0] writeRetain,
  output logic [2*FIELD_W-1:0] minPrefetch,
  output logic [2*FIELD_W-1:0] maxPrefetch
);
  import mode_params_pkg::*;

  logic wpMeta_ff;
  logic wpSync_ff;
  logic writeBackEnable_ff;
  logic scaleSelect_ff;
  logic readCacheBypass_ff;
  logic [3:0] readPrio_ff;
  logic [3:0] writePrio_ff;
  logic [FIELD_W-1:0] disableLen_ff;
  logic [FIELD_W-1:0] minField_ff;
  logic [FIELD_W-1:0] maxField_ff;
  logic [FIELD_W-1:0] ceilField_ff;
  logic [FIELD_W-1:0] xferLen_ff;
  logic [7:0] activeNotch_ff;
  logic [5:0] queryCode_ff;
  logic querySense_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic writeGood_ff;
  logic readCache_ff;
  logic saveReq_ff;
  logic scopeNotch_ff;
  logic [7:0] scopeId_ff;
  logic [1:0] readRetain_ff;
  logic [1:0] writeRetain_ff;
  logic accessDone;
  logic wrEn;
  logic mapped;
  logic selectAll;
  logic [7:0] devSpecific;
  logic [31:0] nxt_prdata;
  page_class_t queryClass;

  // write protect comes from a pin: two flops before use
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wpMeta_ff <= 1'b0;
      wpSync_ff <= 1'b0;
    end else begin
      wpMeta_ff <= writeProtectPin;
      wpSync_ff <= wpMeta_ff;
    end
  end

  // apb completion edge and decode
  assign accessDone = psel && penable && pready_ff;
  assign wrEn = accessDone && pwrite && mapped;
  assign queryClass = classifyPage(queryCode_ff); // see (RL7)
  // a select naming all pages is refused; sense may use it
  assign selectAll = pwrite && (paddr == OFS_PAGE_QUERY) && !pwdata[PQ_SENSE_BIT] &&
                     (classifyPage(pwdata[5:0]) == PG_ALL); // see (RL8)

  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      OFS_HEADER, OFS_PAGE_QUERY, OFS_CACHE_W0, OFS_CACHE_W1,
      OFS_CACHE_W2, OFS_NOTCH, OFS_SAVE, OFS_XFER_LEN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // sense view of the device specific byte, reserved bits zero
  always_comb begin
    devSpecific = 8'h00; // see (RL24)
    devSpecific[DSP_LOCKED_BIT] = wpSync_ff; // see (RL1) (RL3)
    devSpecific[DSP_HINT_BIT] = HINT_SUPPORTED; // see (RL1) (RL5)
  end

  // read mux; density code byte stays zero
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    unique case (paddr)
      OFS_HEADER: nxt_prdata = {24'h00_0000, devSpecific}; // see (RL6)
      OFS_PAGE_QUERY: begin
        nxt_prdata[5:0] = queryCode_ff;
        nxt_prdata[PQ_SENSE_BIT] = querySense_ff;
        nxt_prdata[PQ_ACCEPT_BIT+1 -: 2] = queryClass;
      end
      OFS_CACHE_W0: nxt_prdata = {PAGE_SAVEABLE, 1'b0, PAGE_CACHING, CACHING_PAGE_LEN, // see (RL11) (RL13)
                                  5'h00, writeBackEnable_ff, scaleSelect_ff, readCacheBypass_ff, // see (RL12)
                                  readPrio_ff, writePrio_ff};
      OFS_CACHE_W1: nxt_prdata = {disableLen_ff, minField_ff}; // see (RL12)
      OFS_CACHE_W2: nxt_prdata = {maxField_ff, ceilField_ff}; // see (RL12)
      OFS_NOTCH: nxt_prdata = {15'h0000, scopeNotch_ff, scopeId_ff, activeNotch_ff};
      OFS_XFER_LEN: nxt_prdata = {16'h0000, xferLen_ff};
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end

  // one wait state: pready rises in the second access cycle, falls after completion
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (accessDone) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (psel && penable) begin
      pready_ff <= 1'b1;
      pslverr_ff <= !mapped || selectAll; // see (RL8)
      prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
    end
  end

  // header writes change nothing: locked and hint positions carry no meaning on select
  // caching control bits; saveable flag, code and length in the word are ignored
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      {writeBackEnable_ff, scaleSelect_ff, readCacheBypass_ff} <= CACHE_BITS_RST;
      readPrio_ff <= RET_EQUAL;
      writePrio_ff <= RET_EQUAL;
    end else if (wrEn && paddr == OFS_CACHE_W0) begin
      writeBackEnable_ff <= pwdata[8+WBE_BIT]; // see (RL12) (RL13) (RL2) (RL4)
      scaleSelect_ff <= pwdata[8+SCALE_BIT];
      readCacheBypass_ff <= pwdata[8+BYPASS_BIT];
      readPrio_ff <= pwdata[7:4];
      writePrio_ff <= pwdata[3:0];
    end
  end

  // prefetch words, most significant byte first
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      disableLen_ff <= PREFETCH_FIELD_RST;
      minField_ff <= PREFETCH_FIELD_RST;
      maxField_ff <= PREFETCH_FIELD_RST;
      ceilField_ff <= PREFETCH_FIELD_RST;
    end else if (wrEn && paddr == OFS_CACHE_W1) begin
      disableLen_ff <= pwdata[31:16]; // see (RL12)
      minField_ff <= pwdata[15:0];
    end else if (wrEn && paddr == OFS_CACHE_W2) begin
      maxField_ff <= pwdata[31:16]; // see (RL12)
      ceilField_ff <= pwdata[15:0];
    end
  end

  // current command transfer length feeds the scaled prefetch
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      xferLen_ff <= PREFETCH_FIELD_RST;
    end else if (wrEn && paddr == OFS_XFER_LEN) begin
      xferLen_ff <= pwdata[15:0];
    end
  end

  // page query: a refused all-pages select is not latched
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      queryCode_ff <= PAGE_VENDOR_PLAIN;
      querySense_ff <= 1'b0;
    end else if (wrEn && paddr == OFS_PAGE_QUERY && !selectAll) begin
      queryCode_ff <= pwdata[5:0]; // see (RL7)
      querySense_ff <= pwdata[PQ_SENSE_BIT];
    end
  end

  // notch scope follows the active notch when the notch page exists
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      activeNotch_ff <= 8'h00;
      scopeNotch_ff <= 1'b0;
      scopeId_ff <= 8'h00;
    end else begin
      if (wrEn && paddr == OFS_NOTCH) begin
        activeNotch_ff <= pwdata[7:0];
      end
      scopeNotch_ff <= NOTCH_SUPPORTED && (activeNotch_ff != 8'h00); // see (RL9) (RL10)
      scopeId_ff <= NOTCH_SUPPORTED ? activeNotch_ff : 8'h00; // see (RL10)
    end
  end

  // save request only when the page is saveable and the save flag is set
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      saveReq_ff <= 1'b0;
    end else begin
      saveReq_ff <= wrEn && (paddr == OFS_SAVE) && pwdata[0] && PAGE_SAVEABLE; // see (RL14)
    end
  end

  // write status gate: without write-back the medium must finish first
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      writeGood_ff <= 1'b0;
    end else begin
      writeGood_ff <= writeBackEnable_ff ? writeDataDone : writeMediumDone; // see (RL15) (RL16)
    end
  end

  // cache hit may serve a read only while bypass is off
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      readCache_ff <= 1'b0;
    end else begin
      readCache_ff <= readCacheHit && !readCacheBypass_ff; // see (RL19) (RL20)
    end
  end

  // retention advice for the cache replacement logic
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      readRetain_ff <= KEEP_EQUAL;
      writeRetain_ff <= KEEP_EQUAL;
    end else begin
      readRetain_ff <= decodeRetain(readPrio_ff); // see (RL21) (RL22)
      writeRetain_ff <= decodeRetain(writePrio_ff); // see (RL23) (RL22)
    end
  end

  prefetch_calc #(
    .FIELD_W(FIELD_W)
  ) u_prefetch (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .scaleSelect(scaleSelect_ff),
    .minField(minField_ff),
    .maxField(maxField_ff),
    .ceilField(ceilField_ff),
    .xferLen(xferLen_ff),
    .minBlocks(minPrefetch),
    .maxBlocks(maxPrefetch)
  );

  // outputs straight from flops
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign writeGoodStatus = writeGood_ff;
  assign readFromCache = readCache_ff;
  assign savePageReq = saveReq_ff;
  assign scopeIsNotch = scopeNotch_ff;
  assign scopeNotch = scopeId_ff;
  assign readRetain = readRetain_ff;
  assign writeRetain = writeRetain_ff;

  // checks
  lock_report_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RL3)
    accessDone && !pwrite && paddr == OFS_HEADER |-> prdata_ff[DSP_LOCKED_BIT] == $past(wpSync_ff))
    else $error("locked flag does not match protect state");
  hint_report_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RL5)
    accessDone && !pwrite && paddr == OFS_HEADER |-> prdata_ff[DSP_HINT_BIT] == HINT_SUPPORTED &&
    prdata_ff[6:5] == 2'h0 && prdata_ff[3:0] == 4'h0)
    else $error("hint flag or reserved header bits wrong");
  all_refused_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RL8)
    psel && penable && !pready_ff && selectAll |=> pslverr_ff && pready_ff)
    else $error("all-pages select not refused");
  notch_scope_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RL10)
    ##1 scopeNotch_ff == (NOTCH_SUPPORTED && $past(activeNotch_ff) != 8'h00))
    else $error("notch scope wrong");
  cache_word_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RL11)
    accessDone && !pwrite && paddr == OFS_CACHE_W0 |->
    prdata_ff[29:24] == PAGE_CACHING && prdata_ff[23:16] == CACHING_PAGE_LEN && prdata_ff[31] == PAGE_SAVEABLE)
    else $error("caching page header wrong");
  save_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RL14)
    wrEn && paddr == OFS_SAVE && pwdata[0] |=> saveReq_ff == PAGE_SAVEABLE ##1 !saveReq_ff)
    else $error("save request wrong");
  write_good_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RL15)
    !writeBackEnable_ff && !writeMediumDone |=> !writeGood_ff)
    else $error("good status before medium write");
  early_good_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RL16)
    writeBackEnable_ff && writeDataDone |=> writeGood_ff)
    else $error("write-back good status missing");
  bypass_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RL20)
    readCacheBypass_ff |=> !readCache_ff)
    else $error("cache used under bypass");
  scale_count_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RL18)
    scaleSelect_ff |=>
    minPrefetch == {{FIELD_W{1'b0}}, $past(minField_ff)} * {{FIELD_W{1'b0}}, $past(xferLen_ff)})
    else $error("scaled minimum prefetch wrong");
  query_kept_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RL8)
    accessDone && selectAll |=> $stable(queryCode_ff) && $stable(querySense_ff))
    else $error("refused all-pages select changed the query");
  unit_scope_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RL9)
    activeNotch_ff == 8'h00 |=> !scopeNotch_ff && scopeId_ff == 8'h00)
    else $error("zero notch not whole unit");
  retain_keep_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // see (RL22)
    readPrio_ff == RET_KEEP |=> readRetain_ff == KEEP_LONG)
    else $error("keep priority not decoded");
endmodule
`default_nettype wire

// *** dv/cmd_engine_model.sv ***
// command engine model: write completion events and read cache hits
`default_nettype none
module cmd_engine_model (
  // clock
  input wire logic clk_sys,
  // from the target
  input wire logic writeGoodStatus,
  // events to the target
  output logic writeDataDone,
  output logic writeMediumDone,
  output logic readCacheHit
);
  timeunit 1ns;
  timeprecision 1ps;
  int lagCnt = 0;
  int goodLag = -1;

  initial begin
    writeDataDone = 1'b0;
    writeMediumDone = 1'b0;
    readCacheHit = 1'b0;
  end

  // cycles from data received to the first good status; a later one must not hide an early one
  always @(posedge clk_sys) begin
    lagCnt <= writeDataDone ? 0 : lagCnt + 1;
    if (writeGoodStatus === 1'b1 && goodLag < 0) begin
      goodLag <= lagCnt;
    end
  end

  // medium always finishes after all data arrived, gap cycles later
  task automatic writeCmd(input int gap);
    goodLag = -1;
    @(posedge clk_sys);
    writeDataDone <= 1'b1;
    @(posedge clk_sys);
    writeDataDone <= 1'b0;
    repeat (gap) @(posedge clk_sys);
    writeMediumDone <= 1'b1;
    @(posedge clk_sys);
    writeMediumDone <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  // cache holds the requested data or not
  task automatic setHit(input logic hit);
    @(posedge clk_sys);
    readCacheHit <= hit;
  endtask
endmodule
`default_nettype wire

// *** dv/tb_mode_params_target.sv ***
// testbench of the mode parameter target
`default_nettype none
`define CHK(nm, exp, got) begin cmpCount++; if ((got) !== (exp)) begin nErrors++; \
  $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module tb_mode_params_target;
  timeunit 1ns;
  timeprecision 1ps;
  import mode_params_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic writeProtectPin = 1'b0;
  logic writeDataDone, writeMediumDone, readCacheHit;
  logic writeGoodStatus, readFromCache, savePageReq, scopeIsNotch;
  logic [7:0] scopeNotch;
  logic [1:0] readRetain, writeRetain;
  logic [31:0] minPrefetch, maxPrefetch;
  logic [31:0] rd;
  logic err;
  int nErrors = 0;
  int cmpCount = 0;
  int saveCnt = 0;
  logic [5:0] codes [17] = '{8, 10, 2, 5, 3, 12, 9, 1, 4, 7, 6, 13, 31, 0, 32, 62, 63};
  page_class_t cls [17] = '{PG_KNOWN, PG_KNOWN, PG_KNOWN, PG_KNOWN, PG_KNOWN, PG_KNOWN, PG_KNOWN,
    PG_KNOWN, PG_KNOWN, PG_KNOWN, PG_RESERVED, PG_RESERVED, PG_RESERVED, PG_VENDOR, PG_VENDOR,
    PG_VENDOR, PG_ALL};
  logic [7:0] prio [4] = '{8'h1f, 8'hf1, 8'h52, 8'h0e};
  logic [3:0] retExp [4] = '{4'h7, 4'hd, 4'h0, 4'h0};

  always #2.5 clk_sys = ~clk_sys;

  // count save pulses; a pulse lasts one cycle so it is caught here
  always @(posedge clk_sys) begin
    if (savePageReq === 1'b1) begin
      saveCnt++;
    end
  end

  mode_params_target mode_params_target_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .writeProtectPin(writeProtectPin), .writeDataDone(writeDataDone),
    .writeMediumDone(writeMediumDone), .readCacheHit(readCacheHit),
    .writeGoodStatus(writeGoodStatus), .readFromCache(readFromCache), .savePageReq(savePageReq),
    .scopeIsNotch(scopeIsNotch), .scopeNotch(scopeNotch), .readRetain(readRetain),
    .writeRetain(writeRetain), .minPrefetch(minPrefetch), .maxPrefetch(maxPrefetch)
  );

  cmd_engine_model cmd_engine_model_i (
    .clk_sys(clk_sys), .writeGoodStatus(writeGoodStatus), .writeDataDone(writeDataDone),
    .writeMediumDone(writeMediumDone), .readCacheHit(readCacheHit)
  );

  task automatic giveVerdict();
    if (nErrors == 0 && cmpCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one apb transfer, request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      nErrors++;
      giveVerdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // caching control bits and priority byte, then let outputs settle
  task automatic cache(input logic [2:0] bits, input logic [7:0] pr);
    apb(1'b1, OFS_CACHE_W0, {16'h0, 5'h0, bits, pr});
    repeat (3) @(posedge clk_sys);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    // header byte with protect off then on; select writes must not stick
    apb(1'b1, OFS_HEADER, 32'hffff_ffff);
    apb(1'b0, OFS_HEADER, 32'h0);
    `CHK("header", 32'h0000_0010, rd)
    writeProtectPin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    apb(1'b0, OFS_HEADER, 32'h0);
    `CHK("header wp", 32'h0000_0090, rd)
    // page code classes, sense side
    for (int i = 0; i < 17; i++) begin
      apb(1'b1, OFS_PAGE_QUERY, {23'h0, 1'b1, 2'h0, codes[i]});
      apb(1'b0, OFS_PAGE_QUERY, 32'h0);
      `CHK("class", ({14'h0, cls[i], 7'h0, 1'b1, 2'h0, codes[i]}), rd)
    end
    // refused select must leave the sense query of all pages in place
    apb(1'b1, OFS_PAGE_QUERY, 32'h0000_003f);
    `CHK("all select", 1'b1, err)
    apb(1'b0, OFS_PAGE_QUERY, 32'h0);
    `CHK("query kept", 32'h0002_013f, rd)
    apb(1'b1, OFS_PAGE_QUERY, 32'h0000_0008);
    `CHK("select", 1'b0, err)
    apb(1'b1, 8'h20, 32'h0);
    `CHK("unmapped", 1'b1, err)
    // caching page layout
    apb(1'b1, OFS_CACHE_W0, 32'hffff_ffff);
    apb(1'b0, OFS_CACHE_W0, 32'h0);
    `CHK("cache w0", 32'h880a_07ff, rd)
    // retention nibbles, reserved codes fall to equal
    for (int i = 0; i < 4; i++) begin
      cache(3'h0, prio[i]);
      `CHK("retain", retExp[i], ({readRetain, writeRetain}))
    end
    // good status timing with write-back off and on
    cache(3'h0, 8'h00);
    cmd_engine_model_i.writeCmd(3);
    `CHK("good late", 4, cmd_engine_model_i.goodLag)
    cache(3'h4, 8'h00);
    cmd_engine_model_i.writeCmd(3);
    `CHK("good early", 0, cmd_engine_model_i.goodLag)
    // cache hit honoured only without bypass
    cmd_engine_model_i.setHit(1'b1);
    cache(3'h0, 8'h00);
    `CHK("from cache", 1'b1, readFromCache)
    cache(3'h1, 8'h00);
    `CHK("bypass", 1'b0, readFromCache)
    // prefetch counts plain and scaled by transfer length two
    apb(1'b1, OFS_CACHE_W1, 32'h0000_0003);
    apb(1'b1, OFS_CACHE_W2, 32'h0005_0010);
    apb(1'b1, OFS_XFER_LEN, 32'h0000_0002);
    cache(3'h0, 8'h00);
    `CHK("min plain", 32'd3, minPrefetch)
    `CHK("max plain", 32'd5, maxPrefetch)
    cache(3'h2, 8'h00);
    `CHK("min scaled", 32'd6, minPrefetch)
    `CHK("max scaled", 32'd10, maxPrefetch)
    // notch scope: zero means whole unit
    apb(1'b1, OFS_NOTCH, 32'h0);
    repeat (3) @(posedge clk_sys);
    `CHK("unit scope", 1'b0, scopeIsNotch)
    apb(1'b1, OFS_NOTCH, 32'h5);
    repeat (3) @(posedge clk_sys);
    `CHK("notch scope", 9'h105, ({scopeIsNotch, scopeNotch}))
    // save request only when the flag is set
    apb(1'b1, OFS_SAVE, 32'h1);
    apb(1'b1, OFS_SAVE, 32'h0);
    repeat (3) @(posedge clk_sys);
    `CHK("saves", 1, saveCnt)
    giveVerdict();
  end
endmodule
`default_nettype wire
